// ===== verilog/uart_receive_queue_wakeup.sv
// Receive queue, flow control, wake-up and pin logic of a serial port
`timescale 1ns/1ps
`default_nettype none
module uart_receive_queue_wakeup
  import uart_rx_pkg::*;
#(
  parameter int BAUD16_DIV = BAUD16_CYCLES,
  parameter int COS_DIV    = COS_SAMPLE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       rx_serial_in,
  input  wire logic       multi_function_input,
  output logic            multi_function_output,
  output logic            multi_function_output_oe_n,
  output logic            irq_n
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0]  mode_config_first_reg, mode_config_second_reg;
  logic [7:0]  aux_control_reg, imr_reg, rdata_reg;
  logic        mr_ptr_reg, rx_enable_reg;
  logic [1:0]  rx_sync_reg, mpi_sync_reg;
  logic        line_prev_reg;
  logic [15:0] baud_cnt_reg, cos_cnt_reg;
  logic        tick16_reg, cos_tick_reg;
  rx_state_t   state_reg;
  logic [3:0]  tick_cnt_reg;
  logic [2:0]  bit_idx_reg;
  logic [7:0]  shift_reg;
  logic        par_bit_reg;
  logic [7:0]  q_data_reg [3];
  logic [2:0]  q_stat_reg [3];
  logic [1:0]  wr_ptr_reg, rd_ptr_reg, count_reg;
  logic [2:0]  acc_reg;
  logic        overrun_reg, cos_flag_reg;
  logic        rts_manual_n_reg, rts_auto_neg_reg;
  logic        mpo_reg, mpo_oe_n_reg, irq_n_reg;
  cos_link_if  cos_link ();

  // ------------------------------------------------------------
  // Register bus decode
  // ------------------------------------------------------------
  wire       wr_mode  = reg_wr && (reg_addr == ADDR_MODE);
  wire       rd_mode  = reg_rd && (reg_addr == ADDR_MODE);
  wire       wr_cmd   = reg_wr && (reg_addr == ADDR_COMMAND);
  wire       rhr_read = reg_rd && (reg_addr == ADDR_RHR);
  wire [2:0] cmd      = wr_cmd ? reg_wdata[6:4] : CMD_NOP;
  wire       rx_reset = (cmd == CMD_RX_RESET);
  wire       err_reset = (cmd == CMD_ERR_RESET);
  wire [1:0] par_mode = mode_config_first_reg[4:3];
  wire       wakeup   = (par_mode == PAR_WAKE);
  wire       rx_run   = rx_enable_reg || wakeup;
  wire       line     = rx_sync_reg[1];
  wire [2:0] nbits_m1 = 3'(3'd4 + {1'b0, mode_config_first_reg[1:0]});

  // Mode register pointer steps on any first-register access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mr_ptr_reg             <= 1'b0;
      mode_config_first_reg  <= MODE_RESET;
      mode_config_second_reg <= MODE_RESET;
    end else begin
      if (cmd == CMD_PTR_RESET) mr_ptr_reg <= 1'b0;
      else if ((wr_mode || rd_mode) && !mr_ptr_reg) mr_ptr_reg <= 1'b1;
      if (wr_mode && !mr_ptr_reg) mode_config_first_reg <= reg_wdata;
      if (wr_mode && mr_ptr_reg) mode_config_second_reg <= reg_wdata;
    end
  end

  // Plain control registers and the enable bits of the command word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_control_reg <= AUX_RESET;
      imr_reg         <= IMR_RESET;
      rx_enable_reg   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == ADDR_AUX) aux_control_reg <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_IMR) imr_reg <= reg_wdata;
      if (wr_cmd && reg_wdata[1]) rx_enable_reg <= 1'b0;
      else if (wr_cmd && reg_wdata[0]) rx_enable_reg <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Pin synchronisers and rate dividers
  // ------------------------------------------------------------
  // Both pins are asynchronous; logic reads only the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_sync_reg   <= 2'b11;
      mpi_sync_reg  <= 2'b11;
      line_prev_reg <= 1'b1;
    end else begin
      rx_sync_reg   <= {rx_sync_reg[0], rx_serial_in};
      mpi_sync_reg  <= {mpi_sync_reg[0], multi_function_input};
      line_prev_reg <= rx_sync_reg[1];
    end
  end

  // Sixteen-times bit tick and the input sampling tick
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_cnt_reg <= 16'h0000;
      cos_cnt_reg  <= 16'h0000;
      tick16_reg   <= 1'b0;
      cos_tick_reg <= 1'b0;
    end else begin
      tick16_reg   <= (baud_cnt_reg == 16'(BAUD16_DIV - 1));
      cos_tick_reg <= (cos_cnt_reg == 16'(COS_DIV - 1));
      baud_cnt_reg <= (baud_cnt_reg == 16'(BAUD16_DIV - 1)) ? 16'h0000
                      : 16'(baud_cnt_reg + 16'h0001);
      cos_cnt_reg  <= (cos_cnt_reg == 16'(COS_DIV - 1)) ? 16'h0000
                      : 16'(cos_cnt_reg + 16'h0001);
    end
  end

  // ------------------------------------------------------------
  // Receive shifter
  // ------------------------------------------------------------
  wire start_edge  = line_prev_reg && !line;
  wire mid_bit     = tick16_reg && (tick_cnt_reg == BIT_LAST_TICK);
  wire start_ok    = (state_reg == RX_START) && tick16_reg
                     && (tick_cnt_reg == START_CHECK_TICK) && !line;
  wire rx_done     = (state_reg == RX_STOP) && mid_bit;
  wire stop_bad    = !line;
  wire par_used    = (par_mode != PAR_NONE);
  wire brk         = stop_bad && (shift_reg == 8'h00)
                     && !(par_used && par_bit_reg);
  wire par_calc    = ^shift_reg ^ par_bit_reg
                     ^ mode_config_first_reg[MR1_PAR_TYPE];
  wire par_force_e = par_bit_reg ^ mode_config_first_reg[MR1_PAR_TYPE];
  // Wake-up mode puts the address flag where parity error goes
  wire pe_slot     = wakeup ? par_bit_reg
                     : (par_mode == PAR_WITH) ? par_calc
                     : (par_mode == PAR_FORCE) ? par_force_e : 1'b0;
  wire [2:0] new_stat = {brk, stop_bad, pe_slot};
  // Disabled wake-up receiver keeps only address characters
  wire keep        = rx_enable_reg || par_bit_reg;

  // Leaving the run state drops any half-built character
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= RX_IDLE;
      tick_cnt_reg <= 4'h0;
      bit_idx_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      par_bit_reg  <= 1'b0;
    end else if (!rx_run || rx_reset) begin
      state_reg <= RX_IDLE;
    end else begin
      if (tick16_reg) tick_cnt_reg <= 4'(tick_cnt_reg + 4'h1);
      unique case (state_reg)
        RX_IDLE: begin
          if (start_edge) begin
            state_reg    <= RX_START;
            tick_cnt_reg <= 4'h0;
          end
        end
        RX_START: begin
          if (tick16_reg && tick_cnt_reg == START_CHECK_TICK) begin
            state_reg    <= line ? RX_IDLE : RX_DATA;  // false start check
            tick_cnt_reg <= 4'h0;
            bit_idx_reg  <= 3'h0;
            shift_reg    <= 8'h00;                     // unused MSBs read 0
            par_bit_reg  <= 1'b0;
          end
        end
        RX_DATA: begin
          if (mid_bit) begin
            shift_reg[bit_idx_reg] <= line;
            bit_idx_reg <= 3'(bit_idx_reg + 3'h1);
            if (bit_idx_reg == nbits_m1)
              state_reg <= par_used ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY: begin
          if (mid_bit) begin
            par_bit_reg <= line;
            state_reg   <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (mid_bit) state_reg <= RX_IDLE;  // a break waits for high
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Character queue
  // ------------------------------------------------------------
  function automatic logic [1:0] ptr_inc(input logic [1:0] p);
    ptr_inc = (p == 2'h2) ? 2'h0 : 2'(p + 2'h1);
  endfunction

  wire       q_empty  = (count_reg == 2'h0);
  wire       q_full   = (count_reg == QUEUE_DEPTH);
  wire       pop      = rhr_read && !q_empty;
  wire       push_try = rx_done && keep && !rx_reset;
  wire       push     = push_try && (!q_full || rhr_read);
  wire       overrun  = push_try && q_full && !rhr_read;
  wire [1:0] rd_next  = ptr_inc(rd_ptr_reg);
  wire [1:0] count_up = 2'(count_reg + 2'h1);
  wire [1:0] count_dn = 2'(count_reg - 2'h1);
  wire [2:0] head_stat = q_stat_reg[rd_ptr_reg];
  // A character reaches the head on a push into empty or a deeper pop;
  // a push beside the pop of the last character lands at the head too
  wire       arrive_new = push && (q_empty || (pop && count_reg == 2'h1));
  wire       arrive   = arrive_new || (pop && count_reg > 2'h1);
  wire [2:0] arrive_stat = arrive_new ? new_stat : q_stat_reg[rd_next];
  wire [2:0] acc_next = (err_reset ? 3'h0 : acc_reg)
                        | (arrive ? arrive_stat : 3'h0);

  // Data storage is never cleared; only pointers and status move
  always_ff @(posedge clk) begin
    if (push) begin
      q_data_reg[wr_ptr_reg] <= shift_reg;
      q_stat_reg[wr_ptr_reg] <= new_stat;
    end else if (rx_reset) begin
      q_stat_reg[wr_ptr_reg] <= 3'h0;
    end
  end

  // Reads always step the read pointer, even past empty
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= 2'h0;
      rd_ptr_reg <= 2'h0;
      count_reg  <= 2'h0;
    end else if (rx_reset) begin
      rd_ptr_reg <= wr_ptr_reg;
      count_reg  <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (rhr_read) rd_ptr_reg <= rd_next;
      if (push && !pop) count_reg <= count_up;
      else if (pop && !push) count_reg <= count_dn;
    end
  end

  // Error accumulation; a new event beats a same-cycle clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg     <= 3'h0;
      overrun_reg <= 1'b0;
    end else begin
      acc_reg     <= acc_next;
      overrun_reg <= overrun || (overrun_reg && !err_reset);
    end
  end

  // ------------------------------------------------------------
  // Flow control, change of state and interrupt status
  // ------------------------------------------------------------
  assign cos_link.sample_tick = cos_tick_reg;
  assign cos_link.level       = mpi_sync_reg[1];
  assign cos_link.enable      = aux_control_reg[AUX_COS_EN];

  cos_detect u_cos (
    .clk   (clk),
    .rst_b (rst_b),
    .link  (cos_link.detector)
  );

  wire rts_auto = mode_config_first_reg[MR1_RTS_AUTO];
  wire rx_irq   = mode_config_first_reg[MR1_IRQ_FULL]
                  ? q_full : !q_empty;
  wire [7:0] isr_val = {cos_flag_reg, 4'h0, rx_irq, 2'h0};

  // Request-to-send: manual level, negated in auto mode by a start bit arriving while the queue is full
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rts_manual_n_reg <= 1'b1;
      rts_auto_neg_reg <= 1'b0;
      cos_flag_reg     <= 1'b0;
    end else begin
      if (cmd == CMD_RTS_ON) rts_manual_n_reg <= 1'b0;
      else if (cmd == CMD_RTS_OFF) rts_manual_n_reg <= 1'b1;
      if (rts_auto && start_ok && q_full) rts_auto_neg_reg <= 1'b1;
      else if (!q_full) rts_auto_neg_reg <= 1'b0;
      cos_flag_reg <= cos_link.changed
                      || (cos_flag_reg && cmd != CMD_COS_CLEAR);
    end
  end

  // ------------------------------------------------------------
  // Output pins and read data
  // ------------------------------------------------------------
  wire flow_request_out_n = rts_manual_n_reg || rts_auto_neg_reg;
  wire mpo_irq_type = (aux_control_reg[2:0] == MPO_SEL_RXIRQ);
  wire mpo_val = (aux_control_reg[2:0] == MPO_SEL_RTS)
                 ? flow_request_out_n : (mpo_irq_type ? 1'b0 : 1'b1);
  // Interrupt-type choices pull low only and need an outside pull-up
  wire mpo_oe_n = mpo_irq_type ? !rx_irq : 1'b0;
  wire [2:0] flag_view = mode_config_first_reg[MR1_ERR_BLOCK]
                         ? acc_reg : head_stat;
  // Status read is side-effect free
  wire [7:0] status_val = {flag_view, overrun_reg, 2'h0,
                           q_full, !q_empty};
  wire [7:0] mode_val = mr_ptr_reg ? mode_config_second_reg
                                   : mode_config_first_reg;
  wire [7:0] read_mux = (reg_addr == ADDR_MODE)   ? mode_val
                      : (reg_addr == ADDR_STATUS) ? status_val
                      : (reg_addr == ADDR_RHR)    ? q_data_reg[rd_ptr_reg]
                      : (reg_addr == ADDR_AUX)    ? aux_control_reg
                      : (reg_addr == ADDR_ISR)    ? isr_val
                      : (reg_addr == ADDR_IMR)    ? imr_reg : 8'h00;

  // Read data stand for one cycle only; pins and interrupt registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg    <= 8'h00;
      mpo_reg      <= 1'b1;
      mpo_oe_n_reg <= 1'b0;
      irq_n_reg    <= 1'b1;
    end else begin
      rdata_reg    <= reg_rd ? read_mux : 8'h00;
      mpo_reg      <= mpo_val;
      mpo_oe_n_reg <= mpo_oe_n;
      irq_n_reg    <= !(|(isr_val & imr_reg));
    end
  end

  assign reg_rdata                  = rdata_reg;
  assign multi_function_output      = mpo_reg;
  assign multi_function_output_oe_n = mpo_oe_n_reg;
  assign irq_n                      = irq_n_reg;
endmodule
`default_nettype wire

// ===== include/uart_rx_pkg.sv
// Constants and types shared by the receive-side serial port logic
package uart_rx_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ            = 250_000_000;
  localparam int COS_SAMPLE_HZ     = 38_400;
  localparam int COS_SAMPLE_CYCLES = CLK_HZ / COS_SAMPLE_HZ;
  localparam int BAUD_RATE         = 9600;
  localparam int BAUD16_CYCLES     = CLK_HZ / (BAUD_RATE * 16);
  localparam logic [3:0] START_CHECK_TICK = 4'h7;
  localparam logic [3:0] BIT_LAST_TICK    = 4'hf;

  // ------------------------------------------------------------
  // Register map and reset values
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_MODE    = 3'h0;
  localparam logic [2:0] ADDR_STATUS  = 3'h1;
  localparam logic [2:0] ADDR_COMMAND = 3'h2;
  localparam logic [2:0] ADDR_RHR     = 3'h3;
  localparam logic [2:0] ADDR_AUX     = 3'h4;
  localparam logic [2:0] ADDR_ISR     = 3'h5;
  localparam logic [2:0] ADDR_IMR     = 3'h6;
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] AUX_RESET    = 8'h00;
  localparam logic [7:0] IMR_RESET    = 8'h00;
  localparam logic [1:0] QUEUE_DEPTH  = 2'h3;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int MR1_RTS_AUTO  = 7;
  localparam int MR1_IRQ_FULL  = 6;
  localparam int MR1_ERR_BLOCK = 5;
  localparam int MR1_PAR_TYPE  = 2;
  localparam int SR_AVAIL = 0;
  localparam int SR_FULL  = 1;
  localparam int SR_OVR   = 4;
  localparam int SR_PE    = 5;
  localparam int SR_FE    = 6;
  localparam int SR_BRK   = 7;
  localparam int ISR_RX   = 2;
  localparam int ISR_COS  = 7;
  localparam int AUX_COS_EN = 3;
  localparam logic [2:0] MPO_SEL_RTS  = 3'h0;
  localparam logic [2:0] MPO_SEL_RXIRQ = 3'h1;

  // ------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    PAR_WITH = 2'b00, PAR_FORCE = 2'b01, PAR_NONE = 2'b10, PAR_WAKE = 2'b11
  } parity_mode_t;

  typedef enum logic [2:0] {
    CMD_NOP = 3'b000, CMD_PTR_RESET = 3'b001, CMD_RX_RESET = 3'b010,
    CMD_SPARE = 3'b011, CMD_ERR_RESET = 3'b100, CMD_COS_CLEAR = 3'b101,
    CMD_RTS_ON = 3'b110, CMD_RTS_OFF = 3'b111
  } cmd_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
    RX_PARITY = 3'b011, RX_STOP = 3'b100
  } rx_state_t;
endpackage

// ===== include/cos_link_if.sv
// Carrier between the port core and its change-of-state detector
`timescale 1ns/1ps
`default_nettype none
interface cos_link_if;
  logic sample_tick;
  logic level;
  logic enable;
  logic changed;
  modport detector (input sample_tick, level, enable, output changed);
  modport owner    (output sample_tick, level, enable, input changed);
endinterface
`default_nettype wire

// ===== verilog/cos_detect.sv
// Qualified change-of-state detector for the multi-function input
`timescale 1ns/1ps
`default_nettype none
module cos_detect
  import uart_rx_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_b,
  cos_link_if.detector      link
);
  logic sample_reg;
  logic accepted_reg;
  logic changed_reg;

  // New level needs two equal samples in a row
  wire  qualified = link.sample_tick && (link.level == sample_reg)
                    && (link.level != accepted_reg);

  // While idle the accepted level follows the pin, so enabling is quiet
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_reg   <= 1'b1;
      accepted_reg <= 1'b1;
      changed_reg  <= 1'b0;
    end else begin
      if (link.sample_tick) sample_reg <= link.level;
      if (!link.enable) accepted_reg <= link.level;
      else if (qualified) accepted_reg <= link.level;
      changed_reg <= link.enable && qualified;
    end
  end

  assign link.changed = changed_reg;
endmodule
`default_nettype wire

// ===== sim/uart_rx_monitor.sv
// Port-level assertions for the receive queue block
`timescale 1ns/1ps
`default_nettype none
module uart_rx_monitor
  import uart_rx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       rx_serial_in,
  input  wire logic       multi_function_input,
  input  wire logic       multi_function_output,
  input  wire logic       multi_function_output_oe_n,
  input  wire logic       irq_n
);
  logic [7:0] aux_reg;
  logic [7:0] imr_reg;
  logic [2:0] aux_sel;
  logic       st_rd;
  logic       cmd_wr;
  // ------------------------------------------------------------
  // Shadow copies of host-written control registers
  // ------------------------------------------------------------
  assign aux_sel = aux_reg[2:0];
  assign st_rd   = reg_rd && reg_addr == ADDR_STATUS;
  assign cmd_wr  = reg_wr && reg_addr == ADDR_COMMAND;
  // Shadows update on the same edge as the registers they mirror
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aux_reg <= AUX_RESET;
      imr_reg <= IMR_RESET;
    end else begin
      if (reg_wr && reg_addr == ADDR_AUX)
        aux_reg <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_IMR)
        imr_reg <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_rdata_quiet: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_full_has_avail: assert property (
    $past(st_rd) && reg_rdata[SR_FULL] |-> reg_rdata[SR_AVAIL])
    else $error("full shown without available");
  a_reset_clears_avail: assert property (
    cmd_wr && reg_wdata[6:4] == CMD_RX_RESET ##2 st_rd
    |-> ##1 !reg_rdata[SR_AVAIL])
    else $error("available set after receiver reset");
  a_rts_push_pull: assert property (
    aux_sel == MPO_SEL_RTS && $past(aux_sel) == MPO_SEL_RTS
    |-> !multi_function_output_oe_n)
    else $error("flow output not driven");
  a_open_drain_low: assert property (
    aux_sel == MPO_SEL_RXIRQ && $past(aux_sel) == MPO_SEL_RXIRQ
    && !multi_function_output_oe_n |-> !multi_function_output)
    else $error("open-drain output driven high");
  a_rts_on_cmd: assert property (
    cmd_wr && reg_wdata[6:4] == CMD_RTS_ON && aux_sel == MPO_SEL_RTS
    |-> ##[1:2] !multi_function_output)
    else $error("flow request not asserted");
  a_rts_off_cmd: assert property (
    cmd_wr && reg_wdata[6:4] == CMD_RTS_OFF && aux_sel == MPO_SEL_RTS
    |-> ##[1:2] multi_function_output)
    else $error("flow request not negated");
  a_irq_masked: assert property (
    imr_reg == 8'h00 && $past(imr_reg) == 8'h00 |-> irq_n)
    else $error("interrupt raised while fully masked");
endmodule
bind uart_receive_queue_wakeup uart_rx_monitor i_mon (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rx_serial_in(rx_serial_in), .multi_function_input(multi_function_input),
  .multi_function_output(multi_function_output),
  .multi_function_output_oe_n(multi_function_output_oe_n), .irq_n(irq_n));
`default_nettype wire

// ===== sim/serial_sender.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module serial_sender #(
  parameter int BIT_CYCLES = 32
) (
  input  wire logic clk,
  output var logic  line
);
  // Line rests at mark level between frames
  initial begin
    line = 1'b1;
  end
  // Start, data LSB first, optional address/data flag, one stop bit
  task automatic send(input logic [7:0] d, input logic fl,
                      input logic use_fl, input logic stop);
    logic [10:0] fr;
    fr = use_fl ? {stop, fl, d, 1'b0} : {1'b1, stop, d, 1'b0};
    @(posedge clk);
    for (int i = 0; i < (use_fl ? 11 : 10); i++) begin
      line <= fr[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== sim/uart_receive_queue_wakeup_test.sv
// Self-checking bench for the receive queue block
`timescale 1ns/1ps
`default_nettype none
module uart_receive_queue_wakeup_test import uart_rx_pkg::*;;
  logic       clk;
  logic       rst_b;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       rx_line;
  logic       mfi;
  logic       mfo;
  logic       mfo_oe_n;
  logic       irq_n;
  int         error_cnt;
  int         checked;
  // Short divisors keep each frame at 32 clocks per bit
  uart_receive_queue_wakeup #(.BAUD16_DIV(2), .COS_DIV(4)) i_dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_serial_in(rx_line), .multi_function_input(mfi),
    .multi_function_output(mfo), .multi_function_output_oe_n(mfo_oe_n),
    .irq_n(irq_n));
  serial_sender #(.BIT_CYCLES(32)) i_far (.clk(clk), .line(rx_line));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------------------
  // Bus and compare helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Mode changes only with the receiver off, pointer reset first
  task automatic mode(input logic [7:0] m);
    wr(ADDR_COMMAND, 8'h02);
    wr(ADDR_COMMAND, 8'h10);
    wr(ADDR_MODE, m);
  endtask
  task automatic tx(input logic [7:0] d, input logic f, u, s);
    i_far.send(d, f, u, s);
    repeat (8) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic queue_order;
    mode(8'h53);
    wr(ADDR_COMMAND, 8'h01);
    for (int i = 0; i < 3; i++)
      tx(8'ha1 + 8'(i), 0, 0, 1);
    rd(ADDR_STATUS, 8'h03);
    rd(ADDR_STATUS, 8'h03);
    rd(ADDR_ISR, 8'h04);
    rd(ADDR_RHR, 8'ha1);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_ISR, 8'h00);
    rd(ADDR_RHR, 8'ha2);
    rd(ADDR_RHR, 8'ha3);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_RHR, 8'ha1);
    wr(ADDR_COMMAND, 8'h20);
    rd(ADDR_STATUS, 8'h00);
    tx(8'hd4, 0, 0, 1);
    rd(ADDR_RHR, 8'hd4);
  endtask
  task automatic wake_filter;
    mode(8'h1b);
    tx(8'h11, 0, 1, 1);
    rd(ADDR_STATUS, 8'h00);
    tx(8'h5a, 1, 1, 1);
    rd(ADDR_STATUS, 8'h21);
    rd(ADDR_RHR, 8'h5a);
    wr(ADDR_COMMAND, 8'h01);
    tx(8'h22, 0, 1, 1);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_RHR, 8'h22);
  endtask
  // Character mode, then block mode, same bad-then-good pair
  task automatic error_modes;
    for (int b = 0; b < 2; b++) begin
      mode(b ? 8'h33 : 8'h13);
      wr(ADDR_COMMAND, 8'h41);
      tx(8'h80, 0, 0, 0);
      tx(8'h33, 0, 0, 1);
      rd(ADDR_STATUS, 8'h41);
      rd(ADDR_RHR, 8'h80);
      rd(ADDR_STATUS, b ? 8'h41 : 8'h01);
      rd(ADDR_RHR, 8'h33);
    end
    wr(ADDR_COMMAND, 8'h40);
    rd(ADDR_STATUS, 8'h00);
  endtask
  // Disable in mid-character drops it; the next frame after enable lands
  task automatic drop_partial;
    fork
      tx(8'h5c, 0, 0, 1);
      begin
        repeat (100) @(posedge clk);
        wr(ADDR_COMMAND, 8'h02);
      end
    join
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_COMMAND, 8'h01);
    tx(8'h3e, 0, 0, 1);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_RHR, 8'h3e);
  endtask
  // Odd parity: a wrong parity bit is flagged, a right one is not
  task automatic parity_check;
    mode(8'h07);
    wr(ADDR_COMMAND, 8'h41);
    tx(8'h01, 1, 1, 1);
    rd(ADDR_STATUS, 8'h21);
    rd(ADDR_RHR, 8'h01);
    tx(8'h01, 0, 1, 1);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_RHR, 8'h01);
  endtask
  task automatic flow_control;
    mode(8'h93);
    wr(ADDR_COMMAND, 8'h61);
    for (int i = 0; i < 3; i++)
      tx(8'h70 + 8'(i), 0, 0, 1);
    chk({7'h00, mfo}, 8'h00);
    tx(8'h44, 0, 0, 1);
    chk({7'h00, mfo}, 8'h01);
    rd(ADDR_STATUS, 8'h13);
    rd(ADDR_RHR, 8'h70);
    rd(ADDR_ISR, 8'h04);
    chk({7'h00, mfo}, 8'h00);
    wr(ADDR_AUX, 8'h01);
    repeat (3) @(posedge clk);
    chk({6'h00, mfo, mfo_oe_n}, 8'h00);
    rd(ADDR_RHR, 8'h71);
    rd(ADDR_RHR, 8'h72);
    repeat (3) @(posedge clk);
    chk({7'h00, mfo_oe_n}, 8'h01);
    wr(ADDR_AUX, 8'h00);
    wr(ADDR_COMMAND, 8'h70);
    repeat (3) @(posedge clk);
    chk({7'h00, mfo}, 8'h01);
  endtask
  // A one-clock glitch must not qualify; a held level must
  task automatic change_detect;
    wr(ADDR_AUX, 8'h08);
    wr(ADDR_IMR, 8'h80);
    @(posedge clk) mfi <= 1'b0;
    @(posedge clk) mfi <= 1'b1;
    repeat (30) @(posedge clk);
    rd(ADDR_ISR, 8'h00);
    @(posedge clk) mfi <= 1'b0;
    repeat (30) @(posedge clk);
    rd(ADDR_ISR, 8'h80);
    chk({7'h00, irq_n}, 8'h00);
    wr(ADDR_COMMAND, 8'h50);
    rd(ADDR_ISR, 8'h00);
  endtask
  task automatic complete_run;
    $display("error_cnt=%0d checked=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog bounds the whole run
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    error_cnt = 0;
    checked   = 0;
    rst_b     = 1'b0;
    reg_addr  = 3'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    mfi       = 1'b1;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    queue_order();
    wake_filter();
    error_modes();
    drop_partial();
    parity_check();
    flow_control();
    change_detect();
    complete_run();
  end
endmodule
`default_nettype wire
